// ---- common/tmrwd_pkg.sv ----
// How it works
// - Read restart needs extended features, dual unchained mode and read restart enable set.
// - Counter read captures it, restarts from zero, reloads period in mode 3h.
// - A read restart raises no interrupt, DMA event or output pin event.
// - Every timer timeout outside watchdog mode copies both counter halves into the capture registers.
// - Capture takes counter registers only, never any prescaler count.
// - A counter above its period runs to all ones, wraps, continues to period.
// - Active timer ignores counter, period, most control and global control writes.
// - Reload registers, run bits and enable modes stay writable at all times.
// - Watchdog needs timer mode 2h and enable bit; disabled after hardware reset.
// - Watchdog joins halves into 64 bits; match raises processor reset.
// - Watchdog ignores one-time enable mode and external clocking.
// - Service is key A5C6h then DA7Eh before expiry; clears the counter.
// - Any other key write while active times out at once.
// - Active watchdog ends only by timeout or hardware reset.
// - Timeout clears enable, resets timer; no re-enable until hardware reset.
// - Initial moves to pre-active on enable bit plus key A5C6h while timer mode is 2h.
// - Pre-active accepts watchdog control writes only with a valid key.
// - Pre-active key DA7Eh with enable set clears counters and activates.
// - From pre-active on, counter, period and watchdog control writes are blocked except key.
// - In dual unchained mode clearing a run bit freezes that half; non-watchdog 64-bit modes follow the low run bit only; hardware reset restores defaults.
// - Extended dual unchained mode: low counter compare matches raise interrupt and DMA.
// - Mode 2h wraps to zero and repeats; 3h also reloads the period.
package tmrwd_pkg;

  localparam logic [7:0] OFF_COUNTER_LOW_HALF  = 8'h10;
  localparam logic [7:0] OFF_COUNTER_HIGH_HALF = 8'h14;
  localparam logic [7:0] OFF_PERIOD_LOW_HALF   = 8'h18;
  localparam logic [7:0] OFF_PERIOD_HIGH_HALF  = 8'h1c;
  localparam logic [7:0] OFF_TIMER_CONTROL     = 8'h20;
  localparam logic [7:0] OFF_GLOBAL_CONTROL    = 8'h24;
  localparam logic [7:0] OFF_WATCHDOG_CONTROL  = 8'h28;
  localparam logic [7:0] OFF_RELOAD_LOW_HALF   = 8'h34;
  localparam logic [7:0] OFF_RELOAD_HIGH_HALF  = 8'h38;
  localparam logic [7:0] OFF_CAPTURE_LOW_HALF  = 8'h3c;
  localparam logic [7:0] OFF_CAPTURE_HIGH_HALF = 8'h40;
  localparam logic [7:0] OFF_COMPARE0          = 8'h60;

  // Timer control fields
  localparam int TCR_ENA_LO_POS   = 6;
  localparam int TCR_ENA_HI_POS   = 22;
  localparam int TCR_RRE_POS      = 10;
  localparam int TCR_CAPEN_LO_POS = 11;
  localparam int TCR_CAPEN_HI_POS = 27;
  // Global control fields
  localparam int GLOBAL_TIMER_CONTROL_RUN_LO_POS  = 0;
  localparam int GLOBAL_TIMER_CONTROL_RUN_HI_POS  = 1;
  localparam int GLOBAL_TIMER_CONTROL_TMODE_POS   = 2;
  localparam int GLOBAL_TIMER_CONTROL_PLUS_POS    = 4;
  // Watchdog control fields
  localparam int WDC_EN_POS       = 14;
  localparam int WDC_KEY_POS      = 16;

  localparam logic [15:0] KEY_ARM     = 16'ha5c6;
  localparam logic [15:0] KEY_SERVICE = 16'hda7e;

  localparam logic [1:0] TMODE_GP64      = 2'h0;
  localparam logic [1:0] TMODE_CHAINED   = 2'h1;
  localparam logic [1:0] TMODE_WATCHDOG  = 2'h2;
  localparam logic [1:0] TMODE_UNCHAINED = 2'h3;

  localparam logic [1:0] ENA_OFF    = 2'h0;
  localparam logic [1:0] ENA_ONCE   = 2'h1;
  localparam logic [1:0] ENA_CONT   = 2'h2;
  localparam logic [1:0] ENA_RELOAD = 2'h3;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {WD_INITIAL, WD_PREACTIVE, WD_ACTIVE, WD_TIMEOUT} tmrwd_wd_state_t;

  typedef struct packed {
    logic [1:0] timer_interrupt;
    logic [1:0] timer_dma_event;
    logic [1:0] timer_output_pin;
  } tmrwd_events_t;

  typedef struct packed {
    logic [1:0][31:0] cnt;
    logic [1:0][31:0] prd;
    logic [1:0][31:0] rel;
    logic [1:0][31:0] cap;
    logic [7:0][31:0] cmp;
    logic [1:0][1:0]  ena;
    logic             rre;
    logic [1:0]       capen;
    logic [1:0]       run;
    logic [1:0]       tmode;
    logic             plus;
    logic             watchdog_enable_bit;
    tmrwd_wd_state_t  wd;
    logic             armed;
    logic             aw_got;
    logic             w_got;
    logic [7:0]       awaddr;
    logic [31:0]      wdata;
    logic [3:0]       wstrb;
    logic             bvalid;
    logic [1:0]       bresp;
    logic             rvalid;
    logic [31:0]      rdata;
    logic [1:0]       rresp;
    logic [1:0]       sync1;
    logic [1:0]       sync2;
    logic [1:0]       evt_prev;
    tmrwd_events_t    ev;
    logic             wd_rst;
  } tmrwd_state_t;

endpackage

// ---- rtl/tmrwd_core.sv ----
`timescale 1ns/1ps
module tmrwd_core
  import tmrwd_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          rst_n,
  input  wire logic [7:0]    s_axi_awaddr,
  input  wire logic          s_axi_awvalid,
  output logic               s_axi_awready,
  input  wire logic [31:0]   s_axi_wdata,
  input  wire logic [3:0]    s_axi_wstrb,
  input  wire logic          s_axi_wvalid,
  output logic               s_axi_wready,
  output logic [1:0]         s_axi_bresp,
  output logic               s_axi_bvalid,
  input  wire logic          s_axi_bready,
  input  wire logic [7:0]    s_axi_araddr,
  input  wire logic          s_axi_arvalid,
  output logic               s_axi_arready,
  output logic [31:0]        s_axi_rdata,
  output logic [1:0]         s_axi_rresp,
  output logic               s_axi_rvalid,
  input  wire logic          s_axi_rready,
  input  wire logic [1:0]    capture_event_in,
  output tmrwd_events_t      events,
  output logic               wd_reset_req,
  output logic               wd_active
);

  tmrwd_state_t q;
  tmrwd_state_t s;

  logic        aw_hs;
  logic        w_hs;
  logic        ar_hs;
  logic        do_wr;
  logic [7:0]  wr_a;
  logic [7:0]  ar_a;
  logic        is_unch;
  logic        xf;
  logic        wd_mode;
  logic [1:0]  run_h;
  logic        active;
  logic [1:0]  evt_edge;
  logic [1:0]  rr_fire;
  logic [31:0] wmask;
  logic [31:0] tcr_view;
  logic [31:0] global_timer_control_view;
  logic [31:0] wd_view;
  logic [31:0] tcr_new;
  logic [31:0] global_timer_control_new;
  logic [31:0] wd_new;
  logic [15:0] wr_key;
  logic        key_write;
  logic [31:0] rd_val;
  logic        rd_ok;
  logic [63:0] cnt64;
  logic [63:0] prd64;
  logic [7:0]  cmp_hit;

  assign s_axi_awready = !q.aw_got && !q.bvalid;
  assign s_axi_wready  = !q.w_got && !q.bvalid;
  assign s_axi_arready = !q.rvalid;
  assign s_axi_bvalid  = q.bvalid;
  assign s_axi_bresp   = q.bresp;
  assign s_axi_rvalid  = q.rvalid;
  assign s_axi_rdata   = q.rdata;
  assign s_axi_rresp   = q.rresp;
  assign events        = q.ev;
  assign wd_reset_req  = q.wd_rst;
  assign wd_active     = (q.wd == WD_ACTIVE);

  assign aw_hs   = s_axi_awvalid && s_axi_awready;
  assign w_hs    = s_axi_wvalid && s_axi_wready;
  assign ar_hs   = s_axi_arvalid && s_axi_arready;
  assign do_wr   = q.aw_got && q.w_got;
  assign wr_a    = {q.awaddr[7:2], 2'b00};
  assign ar_a    = {s_axi_araddr[7:2], 2'b00};
  assign is_unch = (q.tmode == TMODE_UNCHAINED);
  assign xf      = q.plus && is_unch;
  assign wd_mode = (q.tmode == TMODE_WATCHDOG) && q.watchdog_enable_bit;
  assign run_h   = {q.run[1] && q.ena[1] != ENA_OFF, q.run[0] && q.ena[0] != ENA_OFF};
  assign active  = |run_h;
  assign evt_edge = q.sync2 & ~q.evt_prev;
  assign cnt64   = {q.cnt[1], q.cnt[0]};
  assign prd64   = {q.prd[1], q.prd[0]};
  assign wmask   = {{8{q.wstrb[3]}}, {8{q.wstrb[2]}}, {8{q.wstrb[1]}}, {8{q.wstrb[0]}}};
  assign tcr_new  = (tcr_view & ~wmask) | (q.wdata & wmask);
  assign global_timer_control_new = (global_timer_control_view & ~wmask) | (q.wdata & wmask);
  assign wd_new   = (wd_view & ~wmask) | (q.wdata & wmask);
  assign wr_key   = wd_new[WDC_KEY_POS +: 16];
  assign key_write = do_wr && (wr_a == OFF_WATCHDOG_CONTROL);

  // Read restart only in extended dual unchained mode
  assign rr_fire[0] = ar_hs && xf && q.rre && (ar_a == OFF_COUNTER_LOW_HALF);
  assign rr_fire[1] = ar_hs && xf && q.rre && (ar_a == OFF_COUNTER_HIGH_HALF);

  for (genvar i = 0; i < 8; i++) begin : g_cmp
    assign cmp_hit[i] = (q.cmp[i] == q.cnt[0]);
  end

  function automatic logic [31:0] merge(input logic [31:0] old);
    return (old & ~wmask) | (q.wdata & wmask);
  endfunction

  function automatic tmrwd_state_t wd_trip(input tmrwd_state_t x);
    tmrwd_state_t y;
    y        = x;
    y.wd     = WD_TIMEOUT;
    y.watchdog_enable_bit   = 1'b0;
    y.cnt    = '0;
    y.armed  = 1'b0;
    y.wd_rst = 1'b1;
    return y;
  endfunction

  // Register views and read decode
  always_comb begin
    tcr_view = '0;
    tcr_view[TCR_ENA_LO_POS +: 2] = q.ena[0];
    tcr_view[TCR_ENA_HI_POS +: 2] = q.ena[1];
    tcr_view[TCR_RRE_POS]         = q.rre;
    tcr_view[TCR_CAPEN_LO_POS]    = q.capen[0];
    tcr_view[TCR_CAPEN_HI_POS]    = q.capen[1];
    global_timer_control_view = '0;
    global_timer_control_view[GLOBAL_TIMER_CONTROL_RUN_LO_POS]    = q.run[0];
    global_timer_control_view[GLOBAL_TIMER_CONTROL_RUN_HI_POS]    = q.run[1];
    global_timer_control_view[GLOBAL_TIMER_CONTROL_TMODE_POS +: 2] = q.tmode;
    global_timer_control_view[GLOBAL_TIMER_CONTROL_PLUS_POS]      = q.plus;
    wd_view = '0;
    wd_view[WDC_EN_POS]           = q.watchdog_enable_bit;
    rd_ok  = 1'b1;
    rd_val = '0;
    case (ar_a)
      OFF_COUNTER_LOW_HALF:  rd_val = q.cnt[0];
      OFF_COUNTER_HIGH_HALF: rd_val = q.cnt[1];
      OFF_PERIOD_LOW_HALF:   rd_val = q.prd[0];
      OFF_PERIOD_HIGH_HALF:  rd_val = q.prd[1];
      OFF_TIMER_CONTROL:     rd_val = tcr_view;
      OFF_GLOBAL_CONTROL:    rd_val = global_timer_control_view;
      OFF_WATCHDOG_CONTROL:  rd_val = wd_view;
      OFF_RELOAD_LOW_HALF:   rd_val = q.rel[0];
      OFF_RELOAD_HIGH_HALF:  rd_val = q.rel[1];
      OFF_CAPTURE_LOW_HALF:  rd_val = q.cap[0];
      OFF_CAPTURE_HIGH_HALF: rd_val = q.cap[1];
      default: begin
        if (ar_a[7:5] == OFF_COMPARE0[7:5]) begin
          rd_val = q.cmp[ar_a[4:2]];
        end else begin
          rd_ok = 1'b0;
        end
      end
    endcase
  end

  always_comb begin
    s          = q;
    s.ev       = '0;
    s.wd_rst   = 1'b0;
    s.sync1    = capture_event_in;
    s.sync2    = q.sync1;
    s.evt_prev = q.sync2;

    // Bus channels
    if (aw_hs) begin
      s.aw_got = 1'b1;
      s.awaddr = s_axi_awaddr;
    end
    if (w_hs) begin
      s.w_got = 1'b1;
      s.wdata = s_axi_wdata;
      s.wstrb = s_axi_wstrb;
    end
    if (q.bvalid && s_axi_bready) begin
      s.bvalid = 1'b0;
    end
    if (q.rvalid && s_axi_rready) begin
      s.rvalid = 1'b0;
    end
    if (ar_hs) begin
      s.rvalid = 1'b1;
      s.rdata  = rd_val;
      s.rresp  = rd_ok ? RESP_OKAY : RESP_SLVERR;
    end

    // Counting; in dual unchained mode a cleared run bit holds that half, in the non-watchdog 64-bit modes only the low run bit holds the count
    if (is_unch) begin
      for (int h = 0; h < 2; h++) begin
        if (run_h[h] && ((q.capen[h] && xf && q.ena[h][1] && evt_edge[h])
                         || q.cnt[h] == q.prd[h])) begin
          s.ev.timer_interrupt[h]  = 1'b1;
          s.ev.timer_dma_event[h]  = 1'b1;
          s.ev.timer_output_pin[h] = 1'b1;
          s.cap = q.cnt;
          if (q.ena[h] == ENA_ONCE) begin
            s.ena[h] = ENA_OFF;
          end else begin
            s.cnt[h] = '0;
          end
          if (q.ena[h] == ENA_RELOAD) begin
            s.prd[h] = q.rel[h];
          end
        end else if (run_h[h]) begin
          s.cnt[h] = q.cnt[h] + 32'h1;
        end
      end
      if (xf && run_h[0] && |cmp_hit) begin
        s.ev.timer_interrupt[0] = 1'b1;
        s.ev.timer_dma_event[0] = 1'b1;
      end
    end else if (wd_mode ? (q.wd == WD_ACTIVE) : run_h[0]) begin
      // Watchdog counts continuously whatever the enable mode
      if (cnt64 == prd64) begin
        if (wd_mode) begin
          s = wd_trip(s);
        end else begin
          s.ev.timer_interrupt[0]  = 1'b1;
          s.ev.timer_dma_event[0]  = 1'b1;
          s.ev.timer_output_pin[0] = 1'b1;
          s.cap = q.cnt;
          if (q.ena[0] == ENA_ONCE) begin
            s.ena[0] = ENA_OFF;
          end else begin
            s.cnt = '0;
          end
          if (q.ena[0] == ENA_RELOAD) begin
            s.prd = q.rel;
          end
        end
      end else begin
        {s.cnt[1], s.cnt[0]} = cnt64 + 64'h1;
      end
    end

    // Read restart: capture, restart, no output events
    for (int h = 0; h < 2; h++) begin
      if (rr_fire[h]) begin
        s.cap    = q.cnt;
        s.cnt[h] = '0;
        if (q.ena[h] == ENA_RELOAD) begin
          s.prd[h] = q.rel[h];
        end
      end
    end

    // Register writes
    if (do_wr) begin
      s.aw_got = 1'b0;
      s.w_got  = 1'b0;
      s.bvalid = 1'b1;
      s.bresp  = RESP_OKAY;
      case (wr_a)
        OFF_COUNTER_LOW_HALF, OFF_COUNTER_HIGH_HALF: begin
          if (!active && q.wd == WD_INITIAL) begin
            s.cnt[wr_a[2]] = merge(q.cnt[wr_a[2]]);
          end
        end
        OFF_PERIOD_LOW_HALF, OFF_PERIOD_HIGH_HALF: begin
          if (!active && q.wd == WD_INITIAL) begin
            s.prd[wr_a[2]] = merge(q.prd[wr_a[2]]);
          end
        end
        OFF_RELOAD_LOW_HALF:  s.rel[0] = merge(q.rel[0]);
        OFF_RELOAD_HIGH_HALF: s.rel[1] = merge(q.rel[1]);
        OFF_CAPTURE_LOW_HALF, OFF_CAPTURE_HIGH_HALF: s.bresp = RESP_OKAY;
        OFF_TIMER_CONTROL: begin
          s.ena[0] = tcr_new[TCR_ENA_LO_POS +: 2];
          s.ena[1] = tcr_new[TCR_ENA_HI_POS +: 2];
          if (!active) begin
            s.rre      = tcr_new[TCR_RRE_POS];
            s.capen[0] = tcr_new[TCR_CAPEN_LO_POS];
            s.capen[1] = tcr_new[TCR_CAPEN_HI_POS];
          end
        end
        OFF_GLOBAL_CONTROL: begin
          s.run[0] = global_timer_control_new[GLOBAL_TIMER_CONTROL_RUN_LO_POS];
          s.run[1] = global_timer_control_new[GLOBAL_TIMER_CONTROL_RUN_HI_POS];
          if (!active && q.wd == WD_INITIAL) begin
            s.tmode = global_timer_control_new[GLOBAL_TIMER_CONTROL_TMODE_POS +: 2];
            s.plus  = global_timer_control_new[GLOBAL_TIMER_CONTROL_PLUS_POS];
          end
        end
        OFF_WATCHDOG_CONTROL: begin
          if (s.wd != WD_TIMEOUT) begin
            unique case (q.wd)
              WD_INITIAL: begin
                s.watchdog_enable_bit = wd_new[WDC_EN_POS];
                if (wd_new[WDC_EN_POS] && wr_key == KEY_ARM
                    && q.tmode == TMODE_WATCHDOG) begin
                  s.wd = WD_PREACTIVE;
                end
              end
              WD_PREACTIVE: begin
                if (wr_key == KEY_ARM || wr_key == KEY_SERVICE) begin
                  s.watchdog_enable_bit = wd_new[WDC_EN_POS];
                  if (wr_key == KEY_SERVICE && wd_new[WDC_EN_POS]) begin
                    s.cnt   = '0;
                    s.armed = 1'b0;
                    s.wd    = WD_ACTIVE;
                  end
                end
              end
              WD_ACTIVE: begin
                if (wr_key == KEY_ARM) begin
                  s.armed = 1'b1;
                end else if (wr_key == KEY_SERVICE && q.armed) begin
                  s.cnt   = '0;
                  s.armed = 1'b0;
                end else begin
                  s = wd_trip(s);
                end
              end
              WD_TIMEOUT: s.watchdog_enable_bit = 1'b0;
            endcase
          end
        end
        default: begin
          if (wr_a[7:5] == OFF_COMPARE0[7:5]) begin
            s.cmp[wr_a[4:2]] = merge(q.cmp[wr_a[4:2]]);
          end else begin
            s.bresp = RESP_SLVERR;
          end
        end
      endcase
    end
  end

  // Hardware reset: every field to zero, watchdog back to initial
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      q <= '0;
    end else begin
      q <= s;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence s_bad_key;
    key_write && q.wd == WD_ACTIVE && wr_key != KEY_ARM && wr_key != KEY_SERVICE;
  endsequence

  sequence s_good_service;
    key_write && q.wd == WD_ACTIVE && q.armed && wr_key == KEY_SERVICE;
  endsequence

  a_timeout_sticky: assert property (
    q.wd == WD_TIMEOUT |=> q.wd == WD_TIMEOUT && !q.watchdog_enable_bit)
    else $error("watchdog left timeout");

  a_timeout_reset_pulse: assert property (
    $rose(q.wd == WD_TIMEOUT) |-> q.wd_rst && q.cnt == '0 ##1 !q.wd_rst)
    else $error("timeout reset pulse wrong");

  a_bad_key_trips: assert property (
    s_bad_key |=> q.wd == WD_TIMEOUT && q.wd_rst)
    else $error("bad key did not trip");

  a_lone_service_trips: assert property (
    key_write && q.wd == WD_ACTIVE && !q.armed && wr_key == KEY_SERVICE
    |=> q.wd == WD_TIMEOUT)
    else $error("unarmed service did not trip");

  a_service_clears: assert property (
    s_good_service |=> q.wd == WD_ACTIVE && q.cnt == '0 && !q.armed)
    else $error("service did not clear counter");

  a_preactive_entry: assert property (
    $rose(q.wd == WD_PREACTIVE) |-> $past(q.tmode) == TMODE_WATCHDOG && q.watchdog_enable_bit)
    else $error("pre-active entered wrongly");

  a_read_restart_quiet: assert property (
    rr_fire[1] && q.cnt[1] != q.prd[1] |=> !q.ev.timer_interrupt[1]
    && !q.ev.timer_output_pin[1] && q.cnt[1] == '0)
    else $error("read restart raised an event");

  a_read_capture: assert property (
    rr_fire[0] |=> q.cap[0] == $past(q.cnt[0]) && q.cap[1] == $past(q.cnt[1]))
    else $error("read restart capture wrong");

  a_period_protected: assert property (
    do_wr && wr_a == OFF_PERIOD_LOW_HALF && active && q.ena[0] != ENA_RELOAD
    |=> $stable(q.prd[0]))
    else $error("active period was written");

  a_run_freeze: assert property (
    is_unch && !q.run[0] && !do_wr && !ar_hs |=> $stable(q.cnt[0]))
    else $error("stopped counter moved");

  a_wrap_max: assert property (
    is_unch && run_h[0] && q.cnt[0] == 32'hffffffff && q.prd[0] != 32'hffffffff
    && !do_wr |=> q.cnt[0] == '0)
    else $error("counter did not wrap");

endmodule

// ---- sim/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
  import tmrwd_pkg::*;
  logic          clk = 1'b0;
  logic          rst_n = 1'b0;
  logic [7:0]    awaddr = 8'h00;
  logic [7:0]    araddr = 8'h00;
  logic          awvalid = 1'b0;
  logic          wvalid = 1'b0;
  logic          bready = 1'b0;
  logic          arvalid = 1'b0;
  logic          rready = 1'b0;
  logic [31:0]   wdata = 32'h0;
  logic [3:0]    wstrb = 4'hf;
  logic [1:0]    cap_in = 2'h0;
  logic [31:0]   seed = 32'h0c80;
  logic [31:0]   rdat, rdata, d1, p, r;
  logic [1:0]    rsp, bresp, rresp;
  logic          awready, wready, bvalid, arready, rvalid, wd_reset_req, wd_active;
  tmrwd_events_t events;
  int            n_mismatch = 0;
  int            n_checks = 0;
  int            n_int = 0;
  int            n_out = 0;
  int            n_wdr = 0;
  int            n_dma = 0;
  int            cyc, k, o;

  always #50 clk = ~clk;

  tmrwd_core dut (
    .clk(clk), .rst_n(rst_n), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .capture_event_in(cap_in), .events(events), .wd_reset_req(wd_reset_req),
    .wd_active(wd_active)
  );

  always @(posedge clk) begin
    if (events.timer_interrupt[0] === 1'b1) n_int++;
    if (events.timer_output_pin[0] === 1'b1) n_out++;
    if (wd_reset_req === 1'b1) n_wdr++;
    if (events.timer_dma_event[0] === 1'b1) n_dma++;
  end

  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction

  task automatic cv(input logic [31:0] g, input logic [31:0] e);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic cb(input logic g, input logic e);
    n_checks++;
    if (g !== e) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int t;
    logic ga, gw;
    ga = 1'b0;
    gw = 1'b0;
    t = 0;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!(ga && gw) && t < 50) begin
      @(posedge clk);
      t++;
      if (!ga && awready === 1'b1) begin
        ga = 1'b1;
        awvalid <= 1'b0;
      end
      if (!gw && wready === 1'b1) begin
        gw = 1'b1;
        wvalid <= 1'b0;
      end
    end
    while (bvalid !== 1'b1 && t < 50) begin
      @(posedge clk);
      t++;
    end
    rsp = bresp;
    bready <= 1'b0;
    if (t >= 50) n_mismatch++;
  endtask

  task automatic rd(input logic [7:0] a);
    int t;
    t = 0;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clk);
      t++;
    end while (arready !== 1'b1 && t < 50);
    arvalid <= 1'b0;
    do begin
      @(posedge clk);
      t++;
    end while (rvalid !== 1'b1 && t < 50);
    rdat = rdata;
    rsp = rresp;
    rready <= 1'b0;
    if (t >= 50) n_mismatch++;
  endtask

  task automatic hw_reset();
    rst_n <= 1'b0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
  endtask

  task automatic wd_on();
    d1 = rnd();
    p = 32'd200 + {25'h0, d1[6:0]};
    wr(OFF_GLOBAL_CONTROL, 32'h8);
    wr(OFF_PERIOD_LOW_HALF, p);
    wr(OFF_PERIOD_HIGH_HALF, 32'h0);
    wr(OFF_WATCHDOG_CONTROL, {KEY_ARM, 16'h4000});
    wr(OFF_WATCHDOG_CONTROL, {KEY_SERVICE, 16'h4000});
  endtask

  task automatic results();
    $display("checks=%0d mismatches=%0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clk);
    n_mismatch++;
    results();
  end

  initial begin
    hw_reset();
    rd(OFF_TIMER_CONTROL);
    cv(rdat, 32'h0);
    rd(8'h04);
    cv({rdat[29:0], rsp}, {30'h0, RESP_SLVERR});
    wr(8'h30, 32'h1);
    cv({30'h0, rsp}, {30'h0, RESP_SLVERR});
    wr(OFF_CAPTURE_LOW_HALF, 32'h5);
    rd(OFF_CAPTURE_LOW_HALF);
    cv(rdat, 32'h0);
    // Compares parked far from every count used below
    for (int i = 0; i < 8; i++) begin
      d1 = rnd();
      wr(OFF_COMPARE0 + 8'(4 * i), 32'h8000_0000 | (d1 & 32'h0fff_ffff));
    end
    wr(OFF_GLOBAL_CONTROL, 32'h1c);
    wr(OFF_COUNTER_LOW_HALF, 32'hffff_fff0);
    wr(OFF_PERIOD_LOW_HALF, 32'h5);
    wr(OFF_TIMER_CONTROL, 32'h80);
    k = n_out;
    wr(OFF_GLOBAL_CONTROL, 32'h1d);
    cyc = 0;
    while (n_out == k && cyc < 100) begin
      @(posedge clk);
      cyc++;
    end
    cb(cyc >= 18 && cyc <= 24, 1'b1);
    rd(OFF_COUNTER_LOW_HALF);
    cb(rdat <= 32'h5, 1'b1);
    wr(OFF_COUNTER_HIGH_HALF, 32'h1234);
    rd(OFF_COUNTER_HIGH_HALF);
    cv(rdat, 32'h0);
    wr(OFF_PERIOD_LOW_HALF, 32'h77);
    rd(OFF_PERIOD_LOW_HALF);
    cv(rdat, 32'h5);
    wr(OFF_GLOBAL_CONTROL, 32'h01);
    rd(OFF_GLOBAL_CONTROL);
    cv(rdat, 32'h1d);
    d1 = rnd();
    r = 32'd100 + {24'h0, d1[7:0]};
    wr(OFF_RELOAD_LOW_HALF, r);
    rd(OFF_RELOAD_LOW_HALF);
    cv(rdat, r);
    wr(OFF_TIMER_CONTROL, 32'h4c0);
    rd(OFF_TIMER_CONTROL);
    cv(rdat, 32'hc0);
    repeat (12) @(posedge clk);
    rd(OFF_PERIOD_LOW_HALF);
    cv(rdat, r);
    wr(OFF_GLOBAL_CONTROL, 32'h1c);
    rd(OFF_COUNTER_LOW_HALF);
    d1 = rdat;
    repeat (10) @(posedge clk);
    rd(OFF_COUNTER_LOW_HALF);
    cv(rdat, d1);
    wr(OFF_COUNTER_LOW_HALF, 32'h0);
    wr(OFF_TIMER_CONTROL, 32'hcc0);
    d1 = rnd();
    r = 32'd100 + {24'h0, d1[7:0]};
    wr(OFF_RELOAD_LOW_HALF, r);
    wr(OFF_GLOBAL_CONTROL, 32'h1d);
    repeat (30) @(posedge clk);
    o = n_out;
    k = n_int;
    rd(OFF_COUNTER_LOW_HALF);
    d1 = rdat;
    rd(OFF_CAPTURE_LOW_HALF);
    cv(rdat, d1);
    rd(OFF_COUNTER_LOW_HALF);
    cb(rdat < 32'd10, 1'b1);
    rd(OFF_PERIOD_LOW_HALF);
    cv(rdat, r);
    // High half read restarts too and captures both halves
    rd(OFF_COUNTER_HIGH_HALF);
    rd(OFF_CAPTURE_HIGH_HALF);
    cv(rdat, 32'h0);
    rd(OFF_CAPTURE_LOW_HALF);
    cb(rdat > 32'h0 && rdat < 32'd20, 1'b1);
    cv(32'(n_out - o), 32'h0);
    cv(32'(n_int - k), 32'h0);
    cap_in <= 2'h1;
    repeat (8) @(posedge clk);
    cb(n_int > k, 1'b1);
    cap_in <= 2'h0;
    wr(OFF_GLOBAL_CONTROL, 32'h1c);
    wr(OFF_GLOBAL_CONTROL, 32'h0d);
    repeat (20) @(posedge clk);
    rd(OFF_COUNTER_LOW_HALF);
    d1 = rdat;
    rd(OFF_COUNTER_LOW_HALF);
    cb(rdat > d1, 1'b1);
    wr(OFF_GLOBAL_CONTROL, 32'h1c);
    wr(OFF_COUNTER_LOW_HALF, 32'h0);
    wr(OFF_PERIOD_LOW_HALF, 32'd1000);
    wr(OFF_COMPARE0, 32'd20);
    wr(OFF_TIMER_CONTROL, 32'h80);
    k = n_int;
    o = n_out;
    wr(OFF_GLOBAL_CONTROL, 32'h1d);
    repeat (40) @(posedge clk);
    cv(32'(n_int - k), 32'h1);
    cv(32'(n_out - o), 32'h0);
    cv(32'(n_dma), 32'(n_int));
    hw_reset();
    wr(OFF_WATCHDOG_CONTROL, {KEY_ARM, 16'h4000});
    wr(OFF_WATCHDOG_CONTROL, {KEY_SERVICE, 16'h4000});
    cb(wd_active, 1'b0);
    k = n_wdr;
    wd_on();
    cb(wd_active, 1'b1);
    wr(OFF_PERIOD_LOW_HALF, 32'h5);
    rd(OFF_PERIOD_LOW_HALF);
    cv(rdat, p);
    for (int i = 0; i < 6; i++) begin
      repeat (60) @(posedge clk);
      wr(OFF_WATCHDOG_CONTROL, {KEY_ARM, 16'h4000});
      wr(OFF_WATCHDOG_CONTROL, {KEY_SERVICE, 16'h4000});
    end
    cv(32'(n_wdr - k), 32'h0);
    wr(OFF_WATCHDOG_CONTROL, {KEY_ARM, 16'h0000});
    cb(wd_active, 1'b1);
    wr(OFF_WATCHDOG_CONTROL, {KEY_SERVICE, 16'h4000});
    wr(OFF_WATCHDOG_CONTROL, {KEY_SERVICE, 16'h4000});
    repeat (2) @(posedge clk);
    cv(32'(n_wdr - k), 32'h1);
    cb(wd_active, 1'b0);
    wr(OFF_WATCHDOG_CONTROL, {KEY_ARM, 16'h4000});
    rd(OFF_WATCHDOG_CONTROL);
    cv(rdat, 32'h0);
    cb(wd_active, 1'b0);
    hw_reset();
    wd_on();
    wr(OFF_WATCHDOG_CONTROL, {16'h1111, 16'h4000});
    repeat (2) @(posedge clk);
    cv(32'(n_wdr - k), 32'h2);
    hw_reset();
    wd_on();
    cyc = 0;
    while (n_wdr == k + 2 && cyc < 1000) begin
      @(posedge clk);
      cyc++;
    end
    cb(cyc + 3 >= p && cyc <= p + 3, 1'b1);
    results();
  end
endmodule
